// >>> rtl/self_program_flash_control.sv
// self-program flash control: command register, sequencer, lock gating
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - lock bits set by software, erased only
// - general lock modes ignored for self access
// - application lock pattern gates stores and loads
// - app modes 3/4 mask interrupts in app
// - boot lock pattern gates stores and loads
// - boot modes 3/4 mask interrupts in boot
// - reset vector from boot_reset_select fuse
// - processor cannot alter any fuse
// - ready interrupt while store_enable is clear
// - erase/write to rww section sets busy
// - busy cleared by reenable or buffer load
// - reenable refused while programming runs
// - reenable during loading discards buffer
// - lock store programs bits from r0
// - load in three cycles reads lock/fuse
// - page write store writes buffer page
// - page erase store erases addressed page
// - stall cpu during halting-section erase/write
// - plain store loads buffer word at z
// - store window four cycles, held while busy
// - only five legal command patterns act; reenable bit discards buffer in any write
module self_program_flash_control
  import self_program_pkg::*;
#(
  parameter int prog_count = prog_cycles,
  parameter logic [15:0] boot_start = boot_start_default,
  parameter logic [15:0] rww_limit = boot_start_default
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // processor instruction side
  input wire logic store_instr,
  input wire logic load_instr,
  input wire logic [15:0] z_addr,
  input wire logic [15:0] store_data,
  input wire logic exec_in_boot,
  input wire logic vectors_in_boot,
  input wire logic global_irq_en,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic load_refused,
  // fuses and chip erase from programming interface
  input wire logic chip_erase,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic boot_reset_select,
  // flash array side
  output logic flash_erase,
  output logic flash_write,
  output logic [15:0] flash_page_addr,
  output logic [15:0] flash_wdata,
  output logic rww_blocked,
  // processor control
  output logic cpu_stall,
  output logic ready_irq,
  output logic irq_suppress,
  output logic [15:0] reset_vector
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic irq_en, rww_busy, reenable, lock_set, page_write, page_erase, store_en;
  logic [2:0] window;
  logic [3:0] lock_bits; // {boot_b2, boot_b1, app_b2, app_b1}
  seq_state_t state;
  logic [15:0] prog_timer;
  logic prog_halting;
  logic loading;
  logic [15:0] buf_rdata;
  logic [5:0] buf_rd_addr;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  wire ctrl_wr = reg_write && reg_addr == ctrl_addr;
  wire [4:0] wr_cmd = reg_wdata[4:0];
  wire busy = state != st_idle;
  wire legal_cmd = wr_cmd == cmd_reenable || wr_cmd == cmd_lock_set ||
                   wr_cmd == cmd_page_write || wr_cmd == cmd_page_erase ||
                   wr_cmd == cmd_buffer_load;
  // new commands are ignored while the flash is busy
  wire cmd_accept = ctrl_wr && legal_cmd && !busy;
  wire win_open = store_en && window != 3'h0 && !busy;
  wire do_store = store_instr && win_open;
  wire target_boot = z_addr >= boot_start;
  wire target_halting = z_addr >= rww_limit;
  // section writes blocked by lock pattern 10 or 00 (b1 low)
  wire app_store_ok = lock_bits[0];
  wire boot_store_ok = lock_bits[2];
  // general lock modes take no part here
  wire store_ok = target_boot ? boot_store_ok : app_store_ok;
  wire go_erase = do_store && page_erase && store_ok;
  wire go_write = do_store && page_write && store_ok;
  wire go_lock = do_store && lock_set;
  wire go_reen = do_store && reenable;
  wire go_load = do_store && !page_erase && !page_write && !lock_set && !reenable;
  // loads across sections blocked by patterns 00 and 01 (b2 low)
  wire load_cross_app = exec_in_boot && !target_boot && !lock_bits[1];
  wire load_cross_boot = !exec_in_boot && target_boot && !lock_bits[3];
  wire load_rww = rww_busy && !target_halting;
  wire fuse_read = load_instr && lock_set && store_en && window > (store_window - load_window);
  wire load_block = load_instr && !fuse_read && (load_cross_app || load_cross_boot || load_rww);
  // z0 low gives the lock byte; with z0 high, z1 picks the fuse byte
  wire [7:0] fuse_word = z_addr[0] ? (z_addr[1] ? fuse_high : fuse_low) :
                         {2'b11, lock_bits, 2'b11};
  wire app_mode34 = !lock_bits[1];
  wire boot_mode34 = !lock_bits[3];
  wire next_suppress = (vectors_in_boot && !exec_in_boot && app_mode34) ||
                       (!vectors_in_boot && exec_in_boot && boot_mode34);
  // status reads as soon as store_enable drops
  wire next_irq = irq_en && global_irq_en && !store_en;
  wire [7:0] ctrl_view = {irq_en, rww_busy, 1'b0, reenable, lock_set,
                          page_write, page_erase, store_en};
  wire [7:0] next_rdata = reg_addr == ctrl_addr ? ctrl_view :
                          reg_addr == lock_addr ? {4'h0, lock_bits} :
                          reg_addr == status_addr ? {5'h0, loading, busy, prog_halting} : 8'h00;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      {irq_en, reenable, lock_set, page_write, page_erase, store_en} <= '0;
      window <= 3'h0;
    end else begin
      if (ctrl_wr) begin
        irq_en <= reg_wdata[bit_irq_en];
      end
      if (cmd_accept) begin
        reenable <= reg_wdata[bit_reenable];
        lock_set <= reg_wdata[bit_lock_set];
        page_write <= reg_wdata[bit_page_write];
        page_erase <= reg_wdata[bit_page_erase];
        store_en <= 1'b1;
        window <= store_window;
      end else if (busy) begin
        if (prog_timer == 16'h0001) begin
          {page_write, page_erase, store_en} <= '0;
        end
      end else if (go_erase || go_write) begin
        window <= 3'h0;
      end else if (store_en && (do_store || window <= 3'h1)) begin
        {reenable, lock_set, page_write, page_erase, store_en} <= '0;
        window <= 3'h0;
      end else if (window != 3'h0) begin
        window <= window - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // rww busy flag and lock bits
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rww_busy <= 1'b0;
    end else if ((go_erase || go_write) && !target_halting) begin
      rww_busy <= 1'b1;
    end else if (go_reen || go_load) begin
      rww_busy <= 1'b0;
    end
  end

  // only chip erase or reset brings bits back to one; the processor can only clear them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lock_bits <= lock_reset;
    end else if (chip_erase) begin
      lock_bits <= lock_reset;
    end else if (go_lock) begin
      lock_bits <= lock_bits & store_data[5:2];
    end
  end

  // ----------------------------------------
  // page sequencer
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= st_idle;
      prog_timer <= 16'h0000;
      prog_halting <= 1'b0;
      flash_page_addr <= 16'h0000;
    end else begin
      case (state)
        st_idle: begin
          if (go_erase || go_write) begin
            state <= go_erase ? st_erase : st_write;
            prog_timer <= 16'(prog_count);
            prog_halting <= target_halting;
            flash_page_addr <= {z_addr[15:7], 7'h00};
          end
        end
        st_erase, st_write: begin
          if (prog_timer == 16'h0001) begin
            state <= st_idle;
            prog_halting <= 1'b0;
          end
          prog_timer <= prog_timer - 16'h0001;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ----------------------------------------
  // temporary buffer loading
  // ----------------------------------------
  wire buf_clear = (ctrl_wr && reg_wdata[bit_reenable]) ||
                   (state == st_write && prog_timer == 16'h0001);
  assign buf_rd_addr = z_addr[6:1];

  always_ff @(posedge clk_sys) begin
    if (reset || buf_clear) begin
      loading <= 1'b0;
    end else if (go_load) begin
      loading <= 1'b1;
    end
  end

  page_buffer_mem u_buffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(go_load),
    .wr_addr(z_addr[6:1]),
    .wr_data(store_data),
    .clear(buf_clear),
    .rd_addr(buf_rd_addr),
    .rd_data(buf_rdata)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      load_data <= 8'h00;
      load_valid <= 1'b0;
      load_refused <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_wdata <= 16'h0000;
      rww_blocked <= 1'b0;
      cpu_stall <= 1'b0;
      ready_irq <= 1'b0;
      irq_suppress <= 1'b0;
      reset_vector <= app_reset_vector;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
      load_data <= fuse_read ? fuse_word : 8'h00;
      load_valid <= fuse_read;
      load_refused <= load_block;
      flash_erase <= go_erase;
      flash_write <= go_write;
      flash_wdata <= buf_rdata;
      rww_blocked <= rww_busy;
      cpu_stall <= busy ? prog_halting && prog_timer != 16'h0001 :
                   (go_erase || go_write) && target_halting;
      ready_irq <= next_irq;
      irq_suppress <= next_suppress;
      // fuse is an input only; nothing here can change it
      reset_vector <= boot_reset_select ? app_reset_vector : boot_start;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
    $past(reg_read) && $past(reg_addr) == ctrl_addr |-> reg_rdata[5] == 1'b0)
    else $error("reserved bit read nonzero");
  window_close_a: assert property (@(posedge clk_sys) disable iff (reset)
    cmd_accept ##1 (!store_instr && !busy && !ctrl_wr) [*4] |=> !store_en)
    else $error("store window exceeded four cycles");
  illegal_cmd_a: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_wr && !legal_cmd && !store_en && !busy |=> !store_en)
    else $error("illegal command acted");
  busy_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    (go_erase || go_write) && !target_halting |=> rww_busy)
    else $error("rww busy not set");
  busy_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    go_load && !go_erase |=> !rww_busy)
    else $error("rww busy not cleared by load");
  lock_one_a: assert property (@(posedge clk_sys) disable iff (reset)
    !chip_erase |=> (lock_bits & ~$past(lock_bits)) == 4'h0)
    else $error("lock bit unprogrammed without chip erase");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (reset)
    irq_en && global_irq_en && !store_en |=> ready_irq)
    else $error("ready interrupt missing");
  stall_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    (go_erase || go_write) && target_halting |=> cpu_stall [*3])
    else $error("cpu not stalled for halting-section program");
  vector_a: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 !$past(boot_reset_select) |-> reset_vector == boot_start)
    else $error("reset vector wrong");
  hold_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
    busy && prog_timer > 16'h0001 |=> store_en)
    else $error("store enable dropped during programming");
  reenable_block_a: assert property (@(posedge clk_sys) disable iff (reset)
    busy && ctrl_wr |=> reenable == $past(reenable))
    else $error("command accepted while programming");
  lock_done_a: assert property (@(posedge clk_sys) disable iff (reset)
    go_lock && !ctrl_wr |=> !lock_set && !store_en)
    else $error("lock command did not self-clear");
  lock_view_a: assert property (@(posedge clk_sys) disable iff (reset)
    fuse_read && !z_addr[0] |=> load_valid && load_data == {2'b11, $past(lock_bits), 2'b11})
    else $error("lock byte readback wrong");
  load_abort_a: assert property (@(posedge clk_sys) disable iff (reset)
    ctrl_wr && reg_wdata[bit_reenable] |=> !loading)
    else $error("buffer load not aborted");
  page_align_a: assert property (@(posedge clk_sys) disable iff (reset)
    (go_erase || go_write) |=> flash_page_addr[6:0] == 7'h00)
    else $error("page address not aligned");
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (reset)
    store_en |=> !ready_irq)
    else $error("ready interrupt while store enable set");
  locked_store_a: assert property (@(posedge clk_sys) disable iff (reset)
    do_store && (page_erase || page_write) && !store_ok |=> !flash_erase && !flash_write)
    else $error("store into locked section acted");
  store_close_a: assert property (@(posedge clk_sys) disable iff (reset)
    do_store && !go_erase && !go_write && !ctrl_wr |=> !store_en)
    else $error("store enable held after store");
  rww_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
    load_rww && load_instr && !fuse_read |=> load_refused)
    else $error("load from busy section not refused");
endmodule : self_program_flash_control
`default_nettype wire

// >>> rtl/self_program_pkg.sv
// self-program flash control: shared constants
package self_program_pkg;

  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] lock_addr = 4'h1;
  localparam logic [3:0] status_addr = 4'h2;
  localparam int bit_irq_en = 7;
  localparam int bit_rww_busy = 6;
  localparam int bit_reenable = 4;
  localparam int bit_lock_set = 3;
  localparam int bit_page_write = 2;
  localparam int bit_page_erase = 1;
  localparam int bit_store_en = 0;
  localparam logic [4:0] cmd_reenable = 5'h11;
  localparam logic [4:0] cmd_lock_set = 5'h09;
  localparam logic [4:0] cmd_page_write = 5'h05;
  localparam logic [4:0] cmd_page_erase = 5'h03;
  localparam logic [4:0] cmd_buffer_load = 5'h01;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [3:0] lock_reset = 4'hF;
  localparam logic [2:0] store_window = 3'h4;
  localparam logic [2:0] load_window = 3'h3;
  localparam int clk_mhz = 250;
  localparam int prog_time_us = 4;
  localparam int prog_cycles = prog_time_us * clk_mhz;
  localparam logic [15:0] boot_start_default = 16'h1C00;
  localparam logic [15:0] app_reset_vector = 16'h0000;
  localparam int buf_words = 64;
  localparam int word_bits = 6;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_erase = 2'b01,
    st_write = 2'b10
  } seq_state_t;

endpackage : self_program_pkg

// >>> rtl/page_buffer_mem.sv
// temporary page buffer with per-word valid bits
`timescale 1ns/1ps
`default_nettype none
module page_buffer_mem
  import self_program_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // write side
  input wire logic wr_en,
  input wire logic [word_bits-1:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic clear,
  // read side
  input wire logic [word_bits-1:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [15:0] mem [buf_words];
  logic [buf_words-1:0] filled;

  // clearing only drops valid bits; stale words read as erased ones
  always_ff @(posedge clk_sys) begin
    if (wr_en && !filled[wr_addr]) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= filled[rd_addr] ? mem[rd_addr] : 16'hFFFF;
  end

  always_ff @(posedge clk_sys) begin
    if (reset || clear) begin
      filled <= '0;
    end else if (wr_en) begin
      filled[wr_addr] <= 1'b1;
    end
  end
endmodule : page_buffer_mem
`default_nettype wire

// >>> verification/proc_core_model.sv
// processor core model: issues store and load program instructions
`timescale 1ns/1ps
`default_nettype none
module proc_core_model (
  // clock
  input wire logic clk_sys,
  // instruction side
  output logic store_instr,
  output logic load_instr,
  output logic [15:0] z_addr,
  output logic [15:0] store_data
);
  // ----------------------------------------
  // instruction issue
  // ----------------------------------------
  initial begin
    store_instr = 1'b0;
    load_instr = 1'b0;
    z_addr = 16'h0000;
    store_data = 16'h0000;
  end
  // one instruction per call, two edges after the control write so it lands inside the window
  task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d);
    @(posedge clk_sys);
    store_instr <= st;
    load_instr <= ~st;
    z_addr <= z;
    store_data <= d;
    @(posedge clk_sys);
    store_instr <= 1'b0;
    load_instr <= 1'b0;
    // operands inverted once released, so a stale value can never look right
    z_addr <= ~z;
    store_data <= ~d;
    #1;
  endtask : issue
endmodule : proc_core_model
`default_nettype wire

// >>> verification/tb.sv
// testbench: register and instruction sequences for self-program control
`timescale 1ns/1ps
`default_nettype none
module tb;
  import self_program_pkg::*;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk_sys, reset, reg_write, reg_read, exec_in_boot, vectors_in_boot, global_irq_en;
  logic chip_erase, boot_reset_select, load_valid, load_refused, flash_erase, flash_write;
  logic rww_blocked, cpu_stall, ready_irq, irq_suppress, store_instr, load_instr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, load_data, fuse_low, fuse_high;
  logic [15:0] z_addr, store_data, flash_page_addr, flash_wdata, reset_vector;
  int miscompares = 0;
  int n_compared = 0;
  self_program_flash_control #(.prog_count(8)) u_dut (.clk_sys, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .store_instr, .load_instr, .z_addr, .store_data,
    .exec_in_boot, .vectors_in_boot, .global_irq_en, .load_data, .load_valid, .load_refused,
    .chip_erase, .fuse_low, .fuse_high, .boot_reset_select, .flash_erase, .flash_write,
    .flash_page_addr, .flash_wdata, .rww_blocked, .cpu_stall, .ready_irq, .irq_suppress,
    .reset_vector);
  proc_core_model u_cpu (.clk_sys, .store_instr, .load_instr, .z_addr, .store_data);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic op(input logic [7:0] c, input logic st, input logic [15:0] z, input logic [15:0] d);
    wr(ctrl_addr, c);
    u_cpu.issue(st, z, d);
  endtask : op
  // bounded poll of the enable bit; running out counts as a mismatch
  task automatic wait_idle;
    logic [7:0] d;
    for (int i = 0; i < 40; i++) begin
      rd(ctrl_addr, d);
      if (d[bit_store_en] === 1'b0) return;
    end
    chk(16'h0001, 16'h0000);
    results();
  endtask : wait_idle
  task automatic lock_read(input logic [7:0] e);
    op(8'h09, 1'b0, 16'h0000, 16'h0000);
    chk({load_valid, load_data}, {1'b1, e});
  endtask : lock_read
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] bad [5];
    logic [7:0] exp_rd [5];
    bad = '{8'h07, 8'h1F, 8'h13, 8'h21, 8'h20};
    exp_rd = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
    reset = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    exec_in_boot = 1'b1;
    vectors_in_boot = 1'b1;
    global_irq_en = 1'b0;
    chip_erase = 1'b0;
    fuse_low = 8'hA5;
    fuse_high = 8'h5A;
    boot_reset_select = 1'b1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    tick(2);
    chk(reset_vector, app_reset_vector);
    rd(ctrl_addr, d);
    chk(d, ctrl_reset);
    boot_reset_select <= 1'b0;
    tick(2);
    chk(reset_vector, boot_start_default);
    // illegal patterns do nothing; the reserved bit reads zero beside a legal one
    foreach (bad[i]) begin
      wr(ctrl_addr, bad[i]);
      rd(ctrl_addr, d);
      chk(d, exp_rd[i]);
    end
    // window runs out before the store
    wr(ctrl_addr, 8'h03);
    tick(5);
    rd(ctrl_addr, d);
    chk(d, 8'h00);
    u_cpu.issue(1'b1, 16'h0100, 16'h0000);
    chk(flash_erase, 1'b0);
    // buffer load then page write into the halting section
    op(8'h01, 1'b1, 16'h1E02, 16'hABCD);
    op(8'h05, 1'b1, 16'h1E02, 16'h0000);
    chk({flash_write, flash_page_addr}, {1'b1, 16'h1E00});
    // the buffer word reaches flash_wdata one cycle after the write pulse
    tick(1);
    chk(flash_wdata, 16'hABCD);
    chk({cpu_stall, rww_blocked}, 2'b10);
    rd(ctrl_addr, d);
    chk(d[bit_store_en], 1'b1);
    wait_idle();
    rd(ctrl_addr, d);
    chk({cpu_stall, d}, 9'h000);
    // erase in the read-while-write section
    op(8'h03, 1'b1, 16'h0100, 16'h0000);
    chk({flash_erase, flash_page_addr}, {1'b1, 16'h0100});
    tick(1);
    chk({cpu_stall, rww_blocked}, 2'b01);
    u_cpu.issue(1'b0, 16'h0200, 16'h0000);
    chk(load_refused, 1'b1);
    op(8'h11, 1'b1, 16'h0000, 16'h0000);
    wait_idle();
    rd(ctrl_addr, d);
    chk(d[bit_rww_busy], 1'b1);
    @(posedge clk_sys);
    global_irq_en <= 1'b1;
    wr(ctrl_addr, 8'h80);
    tick(2);
    chk(ready_irq, 1'b1);
    global_irq_en <= 1'b0;
    tick(2);
    chk(ready_irq, 1'b0);
    op(8'h11, 1'b1, 16'h0000, 16'h0000);
    tick(1);
    chk(rww_blocked, 1'b0);
    op(8'h03, 1'b1, 16'h0100, 16'h0000);
    wait_idle();
    op(8'h01, 1'b1, 16'h0004, 16'h1234);
    tick(1);
    chk(rww_blocked, 1'b0);
    // boot section locked in mode 3, and Z ignored
    op(8'h09, 1'b1, 16'h1234, 16'hFFCF);
    wait_idle();
    lock_read(8'hCF);
    op(8'h09, 1'b0, 16'h0001, 16'h0000);
    chk({load_valid, load_data}, {1'b1, fuse_low});
    op(8'h09, 1'b0, 16'h0003, 16'h0000);
    chk({load_valid, load_data}, {1'b1, fuse_high});
    op(8'h03, 1'b1, 16'h1E00, 16'h0000);
    chk(flash_erase, 1'b0);
    exec_in_boot <= 1'b0;
    u_cpu.issue(1'b0, 16'h1E00, 16'h0000);
    chk(load_refused, 1'b1);
    exec_in_boot <= 1'b1;
    vectors_in_boot <= 1'b0;
    tick(2);
    chk(irq_suppress, 1'b1);
    // application section locked in mode 3 as well
    op(8'h09, 1'b1, 16'h0000, 16'h00C3);
    wait_idle();
    u_cpu.issue(1'b0, 16'h0100, 16'h0000);
    chk(load_refused, 1'b1);
    exec_in_boot <= 1'b0;
    vectors_in_boot <= 1'b1;
    tick(2);
    chk(irq_suppress, 1'b1);
    exec_in_boot <= 1'b1;
    op(8'h03, 1'b1, 16'h0100, 16'h0000);
    chk(flash_erase, 1'b0);
    // software cannot unprogram; only chip erase restores
    op(8'h09, 1'b1, 16'h0000, 16'h00FF);
    wait_idle();
    lock_read(8'hC3);
    @(posedge clk_sys);
    chip_erase <= 1'b1;
    @(posedge clk_sys);
    chip_erase <= 1'b0;
    lock_read(8'hFF);
    rd(lock_addr, d);
    chk(d, 8'h0F);
    // a reenable write while loading throws the loaded words away
    op(8'h01, 1'b1, 16'h0006, 16'h5555);
    rd(status_addr, d);
    chk(d, 8'h04);
    wr(ctrl_addr, 8'h11);
    rd(status_addr, d);
    chk(d, 8'h00);
    op(8'h05, 1'b1, 16'h0006, 16'h0000);
    tick(1);
    chk(flash_wdata, 16'hFFFF);
    wait_idle();
    results();
  end
endmodule : tb
`default_nettype wire
